// ### jlm_link_map.svh
// Offsets, field positions, reset values and timing counts of the link block.
// Assumes a 20 MHz reference clock and byte addresses on the register port.
`ifndef JLM_LINK_MAP_SVH
`define JLM_LINK_MAP_SVH

`define JLM_CLK_MHZ 20
`define JLM_ADDR_W 8
`define JLM_DATA_W 32

// Register offsets
`define JLM_OFS_CTRL 8'h00
`define JLM_OFS_STAT 8'h04

// Control register fields
`define JLM_CTRL_WCM_BIT 0
`define JLM_CTRL_DLOOP_BIT 1
`define JLM_CTRL_ALOOP_BIT 2
`define JLM_CTRL_RESET 3'h0

// Status register fields
`define JLM_STAT_MODE_LSB 0
`define JLM_STAT_FILT_BIT 4
`define JLM_STAT_IDLEW_BIT 5
`define JLM_STAT_RXOK_BIT 6
`define JLM_STAT_CNT_LSB 8

// Filter counter end points
`define JLM_CNT_MAX 4'hF
`define JLM_CNT_MIN 4'h0

// Timing
`define JLM_IDLE_NS 300000
`define JLM_LINK_DIV 20
`define JLM_STAB_CYC 64

`endif

// ### jlm_pkg.sv
// Types shared by the link mode and receive filter logic.
// Assumes nothing beyond a SystemVerilog compiler.
package jlm_pkg;

    typedef enum logic [3:0] {
        JLM_RESET = 4'h1,
        JLM_RUN = 4'h2,
        JLM_WAIT = 4'h4,
        JLM_STOP = 4'h8
    } jlm_mode_t;

    typedef struct packed {
        logic low_voltage_reset;
        logic power_on;
        logic watchdog_reset;
        logic pin;
    } jlm_rst_src_t;

    typedef struct packed {
        logic wait_exec;
        logic stop_exec;
    } jlm_cpu_op_t;

    typedef struct packed {
        logic aloop;
        logic dloop;
        logic wait_clock_mode_bit;
    } jlm_ctrl_t;

endpackage

// ### jlm_link_modes.sv
// Mode sequencer and receive noise filter of a single-wire VPW link controller.
// Assumes synchronous inputs, a 20 MHz ref_clk_i and a protocol handler outside.
//
// How it works
// - Any reset source forces reset mode immediately
// - Reset mode holds registers, outputs, ignores inputs
// - Run mode only after all sources release
// - Wait instruction, clock bit clear: enter wait
// - Wait: bus going active interrupts, returns run
// - Wait: valid end-of-frame also raises interrupt
// - Stop instruction, or wait with bit set: stop
// - Stop halts clocks; activity interrupts, returns run
// - Reception unreliable until clocks settle after stop
// - Digital loopback ties transmit to receive internally
// - Analog loopback keeps digital behaviour unchanged
// - After analog loopback, wait for idle bus
// - Sample on link clock rise, step on fall
// - Counter counts up on high, down on low
// - At fifteen latch sets, counter saturates
// - At zero latch clears, counter saturates
// - Latch holds until opposite end point reached
// - Clean edge delayed fifteen to sixteen periods
// - Pulses shorter than filter delay are removed
// - Longer short pulses reach decoder as invalid
// - Arbitration compare allows for filter delay
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "jlm_link_map.svh"

module jlm_link_modes #(
    parameter int LINK_DIV = `JLM_LINK_DIV,
    parameter int IDLE_CYC = (`JLM_IDLE_NS * `JLM_CLK_MHZ + 999) / 1000,
    parameter int STAB_CYC = `JLM_STAB_CYC,
    parameter int ARB_DLY = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire jlm_pkg::jlm_rst_src_t reset_src_i,
    input wire jlm_pkg::jlm_cpu_op_t cpu_op_i,
    input wire logic raw_receive_input_i,
    input wire logic tx_data_i,
    input wire logic eof_valid_i,
    input wire logic [`JLM_ADDR_W-1:0] addr_i,
    input wire logic [`JLM_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`JLM_DATA_W-1:0] rdata_o,
    output logic transmit_output_o,
    output logic filtered_rx_o,
    output logic rx_ok_o,
    output logic bus_enable_o,
    output logic arb_lost_o,
    output logic wake_irq_o,
    output jlm_pkg::jlm_mode_t mode_o
);

    localparam int DIV_W = $clog2(LINK_DIV);
    localparam int IDLE_W = $clog2(IDLE_CYC + 1);
    localparam int STAB_W = $clog2(STAB_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(LINK_DIV / 2);

    if (LINK_DIV < 2 || IDLE_CYC < 1 || STAB_CYC < 1 || ARB_DLY < 2)
    begin : g_param_check
        $error("jlm_link_modes: parameter out of range");
    end

    // Saturating up/down step of the filter counter
    function automatic logic [3:0] jlm_step(input logic [3:0] cnt, input logic up);
        logic [3:0] res;
        res = cnt;
        if (up && cnt != `JLM_CNT_MAX)
            res = cnt + 4'h1;
        else if (!up && cnt != `JLM_CNT_MIN)
            res = cnt - 4'h1;
        return res;
    endfunction

    logic any_src;
    assign any_src = |reset_src_i;

    jlm_pkg::jlm_ctrl_t ctrl_reg, ctrl_next;
    jlm_pkg::jlm_mode_t mode_reg, mode_next;

    // ----------------------------------------------------------------
    // Link interface clock phases and receive filter
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] div_reg, div_next;
    logic samp_reg, samp_next;
    logic [3:0] cnt_reg, cnt_next;
    logic filt_reg, filt_next;
    logic filt_d_reg, filt_d_next;
    logic rise_ph, fall_ph, clk_run, filt_in;

    assign clk_run = (mode_reg != jlm_pkg::JLM_STOP) && (mode_reg != jlm_pkg::JLM_RESET);
    assign rise_ph = clk_run && (div_reg == '0);
    assign fall_ph = clk_run && (div_reg == DIV_HALF);
    assign filt_in = ctrl_reg.dloop ? tx_data_i : raw_receive_input_i;

    always_comb
    begin
        div_next = div_reg;
        samp_next = samp_reg;
        cnt_next = cnt_reg;
        filt_next = filt_reg;
        filt_d_next = filt_reg;
        if (any_src)
        begin
            div_next = '0;
            samp_next = 1'b0;
            cnt_next = `JLM_CNT_MIN;
            filt_next = 1'b0;
            filt_d_next = 1'b0;
        end
        else if (clk_run)
        begin
            div_next = (div_reg == DIV_LAST) ? '0 : div_reg + DIV_W'(1);
            if (rise_ph)
                samp_next = filt_in;
            if (fall_ph)
            begin
                cnt_next = jlm_step(cnt_reg, samp_reg);
                if (cnt_next == `JLM_CNT_MAX)
                    filt_next = 1'b1;
                else if (cnt_next == `JLM_CNT_MIN)
                    filt_next = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_reg <= '0;
            samp_reg <= 1'b0;
            cnt_reg <= `JLM_CNT_MIN;
            filt_reg <= 1'b0;
            filt_d_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            samp_reg <= samp_next;
            cnt_reg <= cnt_next;
            filt_reg <= filt_next;
            filt_d_reg <= filt_d_next;
        end
    end

    // Filtered level leaves the block unchanged; short pulses never reach 15 or 0,
    // longer ones go on to the decoder, which flags them as invalid.
    assign filtered_rx_o = filt_reg;

    // ----------------------------------------------------------------
    // Operating mode sequencer
    // ----------------------------------------------------------------
    logic irq_reg, irq_next;
    logic [STAB_W-1:0] stab_reg, stab_next;
    logic rx_ok_reg, rx_ok_next;
    logic act_rise;

    assign act_rise = filt_reg && !filt_d_reg;

    always_comb
    begin
        mode_next = mode_reg;
        irq_next = 1'b0;
        stab_next = stab_reg;
        rx_ok_next = rx_ok_reg;
        if (stab_reg != '0)
            stab_next = stab_reg - STAB_W'(1);
        else if (mode_reg == jlm_pkg::JLM_RUN)
            rx_ok_next = 1'b1;
        if (any_src)
        begin
            mode_next = jlm_pkg::JLM_RESET;
            stab_next = '0;
            rx_ok_next = 1'b0;
        end
        else
        begin
            unique case (mode_reg)
                jlm_pkg::JLM_RESET:
                    mode_next = jlm_pkg::JLM_RUN;
                jlm_pkg::JLM_RUN:
                begin
                    if (cpu_op_i.stop_exec ||
                        (cpu_op_i.wait_exec && ctrl_reg.wait_clock_mode_bit))
                    begin
                        mode_next = jlm_pkg::JLM_STOP;
                        rx_ok_next = 1'b0;
                    end
                    else if (cpu_op_i.wait_exec)
                        mode_next = jlm_pkg::JLM_WAIT;
                end
                jlm_pkg::JLM_WAIT:
                begin
                    if (act_rise || eof_valid_i)
                    begin
                        irq_next = 1'b1;
                        mode_next = jlm_pkg::JLM_RUN;
                    end
                end
                jlm_pkg::JLM_STOP:
                begin
                    if (raw_receive_input_i)
                    begin
                        irq_next = 1'b1;
                        mode_next = jlm_pkg::JLM_RUN;
                        stab_next = STAB_W'(STAB_CYC);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_reg <= jlm_pkg::JLM_RESET;
            irq_reg <= 1'b0;
            stab_reg <= '0;
            rx_ok_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            irq_reg <= irq_next;
            stab_reg <= stab_next;
            rx_ok_reg <= rx_ok_next;
        end
    end

    assign mode_o = mode_reg;
    assign wake_irq_o = irq_reg;
    assign rx_ok_o = rx_ok_reg;

    // ----------------------------------------------------------------
    // Transmit path, idle wait and arbitration compare
    // ----------------------------------------------------------------
    logic tx_reg, tx_next;
    logic idlew_reg, idlew_next;
    logic [IDLE_W-1:0] idle_reg, idle_next;
    logic [ARB_DLY-1:0] arb_sh_reg, arb_sh_next;
    logic arb_reg, arb_next;
    logic ben_reg, ben_next;
    logic aloop_exit;

    // Software is trusted to let a frame finish before leaving run mode.
    assign aloop_exit = wr_i && addr_i == `JLM_OFS_CTRL && ctrl_reg.aloop &&
                        !wdata_i[`JLM_CTRL_ALOOP_BIT];

    always_comb
    begin
        idle_next = idle_reg;
        idlew_next = idlew_reg;
        arb_sh_next = arb_sh_reg;
        if (filt_reg)
            idle_next = '0;
        else if (idle_reg != IDLE_W'(IDLE_CYC))
            idle_next = idle_reg + IDLE_W'(1);
        if (aloop_exit && !any_src)
        begin
            idlew_next = 1'b1;
            idle_next = '0;
        end
        else if (idlew_reg && idle_reg == IDLE_W'(IDLE_CYC))
            idlew_next = 1'b0;
        ben_next = (mode_reg == jlm_pkg::JLM_RUN) && !idlew_next;
        // Analog loopback alters nothing on the digital path
        tx_next = ben_next && !ctrl_reg.dloop && tx_data_i;
        arb_next = ben_reg && arb_reg;
        if (rise_ph)
        begin
            arb_sh_next = {arb_sh_reg[ARB_DLY-2:0], tx_reg};
            // Compare at the sample phase, where echo and filter output line up
            arb_next = ben_reg && (arb_sh_reg[ARB_DLY-2] != filt_reg);
        end
        if (any_src)
        begin
            idle_next = '0;
            idlew_next = 1'b0;
            arb_sh_next = '0;
            arb_next = 1'b0;
            ben_next = 1'b0;
            tx_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_reg <= 1'b0;
            idlew_reg <= 1'b0;
            idle_reg <= '0;
            arb_sh_reg <= '0;
            arb_reg <= 1'b0;
            ben_reg <= 1'b0;
        end
        else
        begin
            tx_reg <= tx_next;
            idlew_reg <= idlew_next;
            idle_reg <= idle_next;
            arb_sh_reg <= arb_sh_next;
            arb_reg <= arb_next;
            ben_reg <= ben_next;
        end
    end

    assign transmit_output_o = tx_reg;
    assign arb_lost_o = arb_reg;
    assign bus_enable_o = ben_reg;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic [`JLM_DATA_W-1:0] rdata_reg, rdata_next;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        rdata_next = '0;
        if (any_src)
            ctrl_next = `JLM_CTRL_RESET;
        else
        begin
            if (wr_i && addr_i == `JLM_OFS_CTRL)
            begin
                ctrl_next.wait_clock_mode_bit = wdata_i[`JLM_CTRL_WCM_BIT];
                ctrl_next.dloop = wdata_i[`JLM_CTRL_DLOOP_BIT];
                ctrl_next.aloop = wdata_i[`JLM_CTRL_ALOOP_BIT];
            end
            if (rd_i && addr_i == `JLM_OFS_CTRL)
            begin
                rdata_next[`JLM_CTRL_WCM_BIT] = ctrl_reg.wait_clock_mode_bit;
                rdata_next[`JLM_CTRL_DLOOP_BIT] = ctrl_reg.dloop;
                rdata_next[`JLM_CTRL_ALOOP_BIT] = ctrl_reg.aloop;
            end
            else if (rd_i && addr_i == `JLM_OFS_STAT)
            begin
                rdata_next[`JLM_STAT_MODE_LSB +: 4] = mode_reg;
                rdata_next[`JLM_STAT_FILT_BIT] = filt_reg;
                rdata_next[`JLM_STAT_IDLEW_BIT] = idlew_reg;
                rdata_next[`JLM_STAT_RXOK_BIT] = rx_ok_reg;
                rdata_next[`JLM_STAT_CNT_LSB +: 4] = cnt_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= `JLM_CTRL_RESET;
            rdata_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_RESET_ENTRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        any_src |=> mode_reg == jlm_pkg::JLM_RESET)
        else $error("reset source did not force reset mode");

    AST_RESET_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        any_src |=> !tx_reg && !irq_reg && ctrl_reg == `JLM_CTRL_RESET && cnt_reg == 4'h0)
        else $error("state not held at reset values in reset mode");

    AST_RUN_RELEASE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_reg == jlm_pkg::JLM_RESET && !any_src) |=> mode_reg == jlm_pkg::JLM_RUN)
        else $error("run mode not entered after reset release");

    AST_WAIT_ENTRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_reg == jlm_pkg::JLM_RUN && cpu_op_i.wait_exec && !cpu_op_i.stop_exec &&
         !ctrl_reg.wait_clock_mode_bit && !any_src) |=> mode_reg == jlm_pkg::JLM_WAIT)
        else $error("wait mode not entered");

    AST_WAIT_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_reg == jlm_pkg::JLM_WAIT && act_rise && !any_src)
        |=> irq_reg && mode_reg == jlm_pkg::JLM_RUN)
        else $error("bus activity did not wake from wait");

    AST_EOF_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_reg == jlm_pkg::JLM_WAIT && eof_valid_i && !any_src) |=> irq_reg)
        else $error("end of frame did not raise wake request");

    AST_STOP_ENTRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_reg == jlm_pkg::JLM_RUN && !any_src && (cpu_op_i.stop_exec ||
         (cpu_op_i.wait_exec && ctrl_reg.wait_clock_mode_bit)))
        |=> mode_reg == jlm_pkg::JLM_STOP)
        else $error("stop mode not entered");

    AST_STOP_FROZEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_reg == jlm_pkg::JLM_STOP && !any_src) |=> $stable(cnt_reg) && $stable(div_reg))
        else $error("filter moved while clocks halted");

    AST_DLOOP_QUIET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctrl_reg.dloop |=> !transmit_output_o)
        else $error("bus driven in digital loopback");

    AST_IDLE_WAIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (aloop_exit && !any_src) |=> idlew_reg ##1 !bus_enable_o)
        else $error("bus enabled before idle after analog loopback");

    AST_LATCH_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cnt_reg == 4'hF && fall_ph && samp_reg && !any_src) |=> cnt_reg == 4'hF && filt_reg)
        else $error("counter overflowed or latch not set");

    AST_LATCH_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cnt_reg == 4'h0 |-> !filt_reg)
        else $error("latch set while counter at zero");

    AST_LATCH_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cnt_reg != 4'h0 && cnt_reg != 4'hF) |-> filt_reg == filt_d_reg)
        else $error("latch changed between end points");

    AST_STEP_ON_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!fall_ph && !any_src) |=> $stable(cnt_reg))
        else $error("counter stepped off the falling phase");

endmodule

`default_nettype wire

// ### jlm_xcvr_model.sv
// Behavioural model of the off-chip transceiver and the wired bus it sits on.
// Assumes 1 is the active bus level; slow_i lags the receive path by three cycles.
`timescale 1ns/10ps
`default_nettype none

module jlm_xcvr_model (
    input wire logic clk_i,
    input wire logic tx_i,
    input wire logic node_i,
    input wire logic slow_i,
    output logic rx_o
);
    logic [2:0] lag_reg;
    logic bus;

    // Wired bus: any driver makes it active, otherwise it rests passive
    assign bus = tx_i | node_i;

    always_ff @(posedge clk_i)
    begin
        lag_reg <= {lag_reg[1:0], bus};
    end

    assign rx_o = slow_i ? lag_reg[2] : bus;
endmodule
`default_nettype wire

// ### jlm_link_modes_tb.sv
// Self-checking bench for the link mode sequencer and receive filter.
// Assumes the transceiver model beside it and shortened link and idle counts.
`timescale 1ns/10ps
`default_nettype none
`include "jlm_link_map.svh"

module jlm_link_modes_tb;
    localparam int DIV = 4;
    localparam int IDLE = 20;
    localparam int STAB = 4;
    localparam int LIMIT = 20000;

    logic clk, rst, tx_data, eof, wr, rd, node, slow;
    logic raw_rx, tx_out, filt, rx_ok, bus_en, irq, arb_lost;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    jlm_pkg::jlm_rst_src_t rst_src;
    jlm_pkg::jlm_cpu_op_t cpu_op;
    jlm_pkg::jlm_mode_t mode;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    jlm_link_modes #(.LINK_DIV(DIV), .IDLE_CYC(IDLE), .STAB_CYC(STAB), .ARB_DLY(16))
    i_jlm_link_modes (
        .ref_clk_i(clk), .rst_i(rst), .reset_src_i(rst_src), .cpu_op_i(cpu_op),
        .raw_receive_input_i(raw_rx), .tx_data_i(tx_data), .eof_valid_i(eof),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .transmit_output_o(tx_out), .filtered_rx_o(filt), .rx_ok_o(rx_ok),
        .bus_enable_o(bus_en), .arb_lost_o(arb_lost), .wake_irq_o(irq), .mode_o(mode)
    );

    jlm_xcvr_model i_jlm_xcvr_model (
        .clk_i(clk), .tx_i(tx_out), .node_i(node), .slow_i(slow), .rx_o(raw_rx)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            test_done();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mode(input logic [3:0] e);
        chk_vec("mode", {28'h0, e}, {28'h0, mode});
    endtask

    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic pulse_op(input logic [1:0] op);
        @(posedge clk);
        cpu_op <= jlm_pkg::jlm_cpu_op_t'(op);
        @(posedge clk);
        cpu_op <= jlm_pkg::jlm_cpu_op_t'(2'h0);
        @(negedge clk);
    endtask

    task automatic wait_filt(input logic lvl, output int t);
        t = 0;
        do
        begin
            @(negedge clk);
            t++;
        end
        while (filt !== lvl && t < 90);
    endtask

    task automatic wait_mode(input logic [3:0] m, input int max, output int t);
        t = 0;
        do
        begin
            @(negedge clk);
            t++;
        end
        while (mode !== m && t < max);
    endtask

    task automatic chk_delay(input int t);
        chk_bit("filter delay", 1'b1, t >= 14 * DIV && t <= 17 * DIV);
    endtask

    // Short burst at lvl; the filtered level must never follow it
    task automatic noise(input logic lvl);
        logic bad;
        bad = 1'b0;
        @(posedge clk);
        node <= lvl;
        for (int i = 0; i < 30 * DIV; i++)
        begin
            @(posedge clk);
            if (i == 10 * DIV)
                node <= ~lvl;
            @(negedge clk);
            if (filt !== ~lvl)
                bad = 1'b1;
        end
        chk_bit("filter after noise", 1'b0, bad);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs;
        logic [31:0] d;
        reg_rd(`JLM_OFS_CTRL, d);
        chk_vec("control at reset", 32'h0, d);
        reg_wr(`JLM_OFS_CTRL, 32'h0000_0001);
        reg_rd(`JLM_OFS_CTRL, d);
        chk_vec("control", 32'h0000_0001, d);
        reg_rd(8'h08, d);
        chk_vec("unmapped read", 32'h0, d);
        reg_wr(`JLM_OFS_CTRL, 32'h0);
    endtask

    task automatic s_sources;
        logic [31:0] d;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            rst_src <= jlm_pkg::jlm_rst_src_t'(4'h1 << k);
            tx_data <= 1'b1;
            settle();
            chk_mode(jlm_pkg::JLM_RESET);
            reg_wr(`JLM_OFS_CTRL, 32'h0000_0001);
            @(negedge clk);
            chk_bit("drive in reset", 1'b0, tx_out);
            @(posedge clk);
            rst_src <= jlm_pkg::jlm_rst_src_t'(4'h0);
            tx_data <= 1'b0;
            settle();
            chk_mode(jlm_pkg::JLM_RUN);
            reg_rd(`JLM_OFS_CTRL, d);
            chk_vec("control after source", 32'h0, d);
        end
    endtask

    task automatic s_filter;
        int t;
        logic [31:0] d;
        noise(1'b1);
        @(posedge clk);
        node <= 1'b1;
        wait_filt(1'b1, t);
        chk_delay(t);
        repeat (10 * DIV) @(posedge clk);
        reg_rd(`JLM_OFS_STAT, d);
        chk_vec("status high", 32'h0000_0F12, d & 32'h0000_0F1F);
        noise(1'b0);
        @(posedge clk);
        node <= 1'b0;
        wait_filt(1'b0, t);
        chk_delay(t);
        repeat (10 * DIV) @(posedge clk);
        reg_rd(`JLM_OFS_STAT, d);
        chk_vec("status low", 32'h0000_0002, d & 32'h0000_0F1F);
    endtask

    task automatic s_dloop;
        int t;
        reg_wr(`JLM_OFS_CTRL, 32'h0000_0002);
        tx_data <= 1'b1;
        wait_filt(1'b1, t);
        chk_delay(t);
        chk_bit("drive in loopback", 1'b0, tx_out);
        chk_bit("bus in loopback", 1'b0, raw_rx);
        @(posedge clk);
        tx_data <= 1'b0;
        wait_filt(1'b0, t);
        reg_wr(`JLM_OFS_CTRL, 32'h0);
    endtask

    task automatic s_aloop;
        int t;
        reg_wr(`JLM_OFS_CTRL, 32'h0000_0004);
        tx_data <= 1'b1;
        settle();
        chk_bit("drive in analog loopback", 1'b1, tx_out);
        @(posedge clk);
        tx_data <= 1'b0;
        repeat (40 * DIV) @(posedge clk);
        reg_wr(`JLM_OFS_CTRL, 32'h0);
        settle();
        chk_bit("enable after loopback", 1'b0, bus_en);
        t = 0;
        do
        begin
            @(negedge clk);
            t++;
        end
        while (bus_en !== 1'b1 && t < 60);
        chk_bit("idle wait length", 1'b1, t >= IDLE - 4 && t <= IDLE + 6);
    endtask

    task automatic s_arb;
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        tx_data <= 1'b1;
        repeat (20 * DIV)
        begin
            @(negedge clk);
            seen = seen | arb_lost;
        end
        chk_bit("pulse passed", 1'b1, filt);
        @(posedge clk);
        tx_data <= 1'b0;
        repeat (20 * DIV)
        begin
            @(negedge clk);
            seen = seen | arb_lost;
        end
        chk_bit("own echo lost", 1'b0, seen);
        @(posedge clk);
        node <= 1'b1;
        repeat (20 * DIV) @(posedge clk);
        @(negedge clk);
        chk_bit("foreign bit lost", 1'b1, arb_lost);
        @(posedge clk);
        node <= 1'b0;
        repeat (20 * DIV) @(posedge clk);
    endtask

    task automatic s_wait;
        int t;
        pulse_op(2'h2);
        chk_mode(jlm_pkg::JLM_WAIT);
        @(posedge clk);
        node <= 1'b1;
        wait_mode(jlm_pkg::JLM_RUN, 90, t);
        chk_delay(t);
        chk_bit("wake request", 1'b1, irq);
        @(negedge clk);
        chk_bit("wake request end", 1'b0, irq);
        @(posedge clk);
        node <= 1'b0;
        wait_filt(1'b0, t);
        pulse_op(2'h2);
        chk_mode(jlm_pkg::JLM_WAIT);
        @(posedge clk);
        eof <= 1'b1;
        @(posedge clk);
        eof <= 1'b0;
        wait_mode(jlm_pkg::JLM_RUN, 3, t);
        chk_mode(jlm_pkg::JLM_RUN);
        chk_bit("frame end wake", 1'b1, irq);
    endtask

    task automatic s_stop;
        int t;
        @(posedge clk);
        slow <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            reg_wr(`JLM_OFS_CTRL, k == 1 ? 32'h0000_0001 : 32'h0);
            pulse_op(k == 1 ? 2'h2 : 2'h1);
            chk_mode(jlm_pkg::JLM_STOP);
            @(posedge clk);
            node <= 1'b1;
            wait_mode(jlm_pkg::JLM_RUN, 8, t);
            chk_mode(jlm_pkg::JLM_RUN);
            chk_bit("stop wake", 1'b1, irq);
            chk_bit("trust after stop", 1'b0, rx_ok);
            repeat (STAB + 4) @(posedge clk);
            @(negedge clk);
            chk_bit("trust settled", 1'b1, rx_ok);
            @(posedge clk);
            node <= 1'b0;
            repeat (40 * DIV) @(posedge clk);
        end
        reg_wr(`JLM_OFS_CTRL, 32'h0);
        slow <= 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        rst_src = jlm_pkg::jlm_rst_src_t'(4'h0);
        cpu_op = jlm_pkg::jlm_cpu_op_t'(2'h0);
        tx_data = 1'b0;
        eof = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        node = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk_mode(jlm_pkg::JLM_RESET);
        @(posedge clk);
        rst <= 1'b0;
        settle();
        chk_mode(jlm_pkg::JLM_RUN);
        chk_bit("filtered after reset", 1'b0, filt);
        s_regs();
        s_sources();
        s_filter();
        s_dloop();
        s_aloop();
        s_arb();
        s_wait();
        s_stop();
        test_done();
    end
endmodule
`default_nettype wire
